// ### core/dcc_top.v
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "dcc_defines.vh"

module dcc_top #(
  parameter ADDR_W = 12
) (
  // Clock and reset
  input  wire              hclk,
  input  wire              hresetn,
  input  wire              ce,
  // AHB-Lite slave
  input  wire              hsel,
  input  wire [ADDR_W-1:0] haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire [31:0]       hwdata,
  input  wire              hready,
  output wire              hreadyout,
  output wire              hresp,
  output reg  [31:0]       hrdata,
  // Analog comparator results, asynchronous
  input  wire              first_raw,
  input  wire              second_raw,
  // Analog multiplexer controls
  output reg  [2:0]        first_inv_sel,
  output reg  [2:0]        first_pos_sel,
  output reg  [2:0]        second_inv_sel,
  output reg  [2:0]        second_pos_sel,
  output reg               first_power,
  output reg               second_power,
  output reg  [3:0]        pin_analog,
  // Port pins
  input  wire [4:0]        port_data,
  output wire [4:0]        pin_out,
  output wire [4:0]        pin_oe,
  // Interrupt
  output wire              irq
);

  // ----------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------
  reg              dp_valid;
  reg              dp_write;
  reg [ADDR_W-3:0] dp_index;

  wire             ap_take;
  wire [ADDR_W-3:0] ap_index;

  assign ap_take   = hsel & hready & htrans[1];
  assign ap_index  = haddr[ADDR_W-1:2];
  assign hreadyout = ce;
  assign hresp     = `DCC_HRESP_OKAY;

  function hit;
    input [ADDR_W-3:0] idx;
    input [9:0]        reg_idx;
    begin
      hit = (idx == reg_idx[ADDR_W-3:0]);
    end
  endfunction

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_index <= {(ADDR_W-2){1'b0}};
    end else if (ce) begin
      dp_valid <= ap_take;
      if (ap_take) begin
        dp_write <= hwrite;
        dp_index <= ap_index;
      end
    end
  end

  // ----------------------------------------------------------------
  // Comparator result synchronisers
  // ----------------------------------------------------------------
  reg [1:0] res_meta;
  reg [1:0] res_sync;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_meta <= 2'b00;
      res_sync <= 2'b00;
    end else if (ce) begin
      res_meta <= {second_raw, first_raw};
      res_sync <= res_meta;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [2:0] compare_mode_field;
  reg       input_switch_select;
  reg [4:0] port_a_direction;
  reg       compare_change_flag;
  reg       compare_irq_enable;
  reg       peripheral_irq_enable;
  reg       global_irq_enable;
  reg [1:0] result_snapshot;

  wire wr_phase;
  wire ctrl_access;
  wire ctrl_write;
  wire dir_write;
  wire clear_write;
  wire enable_write;
  wire gate_write;
  wire mismatch;
  wire next_flag;

  assign wr_phase     = dp_valid & dp_write;
  assign ctrl_access  = dp_valid & hit(dp_index, `DCC_IDX_CTRL);
  assign ctrl_write   = wr_phase & hit(dp_index, `DCC_IDX_CTRL);
  assign dir_write    = wr_phase & hit(dp_index, `DCC_IDX_DIR);
  assign clear_write  = wr_phase & hit(dp_index, `DCC_IDX_CLEAR);
  assign enable_write = wr_phase & hit(dp_index, `DCC_IDX_ENABLE);
  assign gate_write   = wr_phase & hit(dp_index, `DCC_IDX_GATE);

  // Synced results differ from the snapshot of the last control access
  assign mismatch  = (res_sync != result_snapshot);
  // Set wins over a clear in the same cycle
  assign next_flag = mismatch | (compare_change_flag & ~(clear_write & hwdata[0]));

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_mode_field  <= `DCC_MODE_RESET;
      input_switch_select <= 1'b0;
      port_a_direction    <= `DCC_DIR_RESET;
    end else if (ce) begin
      if (ctrl_write) begin
        compare_mode_field  <= hwdata[`DCC_MODE_HI:0];
        input_switch_select <= hwdata[`DCC_CTRL_SWITCH];
      end
      if (dir_write) begin
        port_a_direction <= hwdata[4:0];
      end
    end
  end

  // Snapshot refreshed on any control access ends the change condition
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_snapshot <= 2'b00;
    end else if (ce) begin
      if (ctrl_access) begin
        result_snapshot <= res_sync;
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_change_flag <= 1'b0;
    end else if (ce) begin
      compare_change_flag <= next_flag;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_irq_enable    <= 1'b0;
      peripheral_irq_enable <= 1'b0;
      global_irq_enable     <= 1'b0;
    end else if (ce) begin
      if (enable_write) begin
        compare_irq_enable <= hwdata[0];
      end
      if (gate_write) begin
        peripheral_irq_enable <= hwdata[`DCC_GATE_PERIPH];
        global_irq_enable     <= hwdata[`DCC_GATE_GLOBAL];
      end
    end
  end

  // Flag is set regardless of enables; request needs all three
  assign irq = compare_change_flag & compare_irq_enable
             & peripheral_irq_enable & global_irq_enable;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  reg  [31:0] next_rdata;
  wire [7:0]  ctrl_view;

  // Results read-only, bits 5 and 4 read zero
  assign ctrl_view = {res_sync[1], res_sync[0], 2'b00,
                      input_switch_select, compare_mode_field};

  always @* begin
    next_rdata = 32'h0000_0000;
    if (hit(ap_index, `DCC_IDX_CTRL)) begin
      next_rdata = {24'h00_0000, ctrl_view};
    end else if (hit(ap_index, `DCC_IDX_DIR)) begin
      next_rdata = {27'h000_0000, port_a_direction};
    end else if (hit(ap_index, `DCC_IDX_STATUS)) begin
      next_rdata = {31'h0000_0000, compare_change_flag};
    end else if (hit(ap_index, `DCC_IDX_ENABLE)) begin
      next_rdata = {31'h0000_0000, compare_irq_enable};
    end else if (hit(ap_index, `DCC_IDX_GATE)) begin
      next_rdata = {30'h0000_0000, global_irq_enable, peripheral_irq_enable};
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ce) begin
      if (ap_take & ~hwrite) begin
        hrdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Multiplexer decode
  // ----------------------------------------------------------------
  wire [2:0] dec_first_inv;
  wire [2:0] dec_first_pos;
  wire [2:0] dec_second_inv;
  wire [2:0] dec_second_pos;
  wire       dec_first_power;
  wire       dec_second_power;
  wire [3:0] dec_pin_analog;
  wire       result_drive;

  dcc_mux_decode u_decode (
    .compare_mode_field  (compare_mode_field),
    .input_switch_select (input_switch_select),
    .first_inv_sel       (dec_first_inv),
    .first_pos_sel       (dec_first_pos),
    .second_inv_sel      (dec_second_inv),
    .second_pos_sel      (dec_second_pos),
    .first_power         (dec_first_power),
    .second_power        (dec_second_power),
    .pin_analog          (dec_pin_analog),
    .result_drive        (result_drive)
  );

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_inv_sel  <= `DCC_SEL_NONE;
      first_pos_sel  <= `DCC_SEL_NONE;
      second_inv_sel <= `DCC_SEL_NONE;
      second_pos_sel <= `DCC_SEL_NONE;
      first_power    <= 1'b0;
      second_power   <= 1'b0;
      pin_analog     <= 4'hF;
    end else if (ce) begin
      first_inv_sel  <= dec_first_inv;
      first_pos_sel  <= dec_first_pos;
      second_inv_sel <= dec_second_inv;
      second_pos_sel <= dec_second_pos;
      first_power    <= dec_first_power;
      second_power   <= dec_second_power;
      pin_analog     <= dec_pin_analog;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Direction bit low means the pin drives, in every mode
  assign pin_oe = ~port_a_direction;

  // Raw comparator outputs bypass the synchronisers on purpose
  assign pin_out[2:0] = port_data[2:0];
  assign pin_out[3]   = result_drive ? first_raw  : port_data[3];
  assign pin_out[4]   = result_drive ? second_raw : port_data[4];

endmodule // dcc_top

// ### core/dcc_defines.vh
// Operation
// - Two comparators take their inputs from port pins 0 to 3 by mode.
// - The internal reference voltage can feed the comparators in modes that route it.
// - Control bits 2 to 0 pick one of eight multiplexer modes.
// - Control bit 6 shows comparator one's result, read-only, zero after reset.
// - Control bits 7 and 6 show both current comparator results, read-only.
// - Control bits 5 and 4 ignore writes and read zero.
// - Mode 001: switch bit picks pin 3 or pin 0 for comparator one's inverting input.
// - Mode 010: switch set routes inverting inputs to pins 3 and 2, else default pins.
// - The direction register always decides whether each comparator pin drives.
// - Mode 011 uses pins 0 and 1 inverting, pin 2 shared non-inverting input.
// - Reading the control register ends the pending change condition.
// - Any result change sets the flag; interrupt needs all three enables set.
// - Reset puts mode 000: pins analog, comparators powered down.
// - Mode 110 drives pins 3 and 4 with raw comparator outputs, direction-gated.
`ifndef DCC_DEFINES_VH
`define DCC_DEFINES_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define DCC_IDX_CTRL      10'h01F
`define DCC_IDX_DIR       10'h085
`define DCC_IDX_STATUS    10'h020
`define DCC_IDX_CLEAR     10'h021
`define DCC_IDX_ENABLE    10'h022
`define DCC_IDX_GATE      10'h023

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define DCC_CTRL_RES2     7
`define DCC_CTRL_RES1     6
`define DCC_CTRL_SWITCH   3
`define DCC_MODE_HI       2
`define DCC_MODE_RESET    3'h0
`define DCC_DIR_RESET     5'h1F
`define DCC_GATE_PERIPH   0
`define DCC_GATE_GLOBAL   1

// ----------------------------------------------------------------
// Modes
// ----------------------------------------------------------------
`define DCC_MODE_RESETM   3'h0
`define DCC_MODE_THREE    3'h1
`define DCC_MODE_FOURREF  3'h2
`define DCC_MODE_COMMON   3'h3
`define DCC_MODE_INDEP    3'h4
`define DCC_MODE_SINGLE   3'h5
`define DCC_MODE_OUTPUTS  3'h6
`define DCC_MODE_OFF      3'h7

// ----------------------------------------------------------------
// Analog input selector codes
// ----------------------------------------------------------------
`define DCC_SEL_NONE      3'h0
`define DCC_SEL_PIN0      3'h1
`define DCC_SEL_PIN1      3'h2
`define DCC_SEL_PIN2      3'h3
`define DCC_SEL_PIN3      3'h4
`define DCC_SEL_VREF      3'h5

// ----------------------------------------------------------------
// Bus encodings
// ----------------------------------------------------------------
`define DCC_HRESP_OKAY    1'b0

`endif

// ### core/dcc_mux_decode.v
`timescale 1ns/10ps
`include "dcc_defines.vh"

module dcc_mux_decode (
  // Control
  input  wire [2:0] compare_mode_field,
  input  wire       input_switch_select,
  // Multiplexer selects
  output reg  [2:0] first_inv_sel,
  output reg  [2:0] first_pos_sel,
  output reg  [2:0] second_inv_sel,
  output reg  [2:0] second_pos_sel,
  output reg        first_power,
  output reg        second_power,
  output reg  [3:0] pin_analog,
  output reg        result_drive
);

  always @* begin
    first_inv_sel  = `DCC_SEL_NONE;
    first_pos_sel  = `DCC_SEL_NONE;
    second_inv_sel = `DCC_SEL_NONE;
    second_pos_sel = `DCC_SEL_NONE;
    first_power    = 1'b0;
    second_power   = 1'b0;
    pin_analog     = 4'h0;
    result_drive   = 1'b0;
    case (compare_mode_field)
      `DCC_MODE_RESETM: begin
        pin_analog = 4'hF;
      end
      `DCC_MODE_THREE: begin
        first_inv_sel  = input_switch_select ? `DCC_SEL_PIN3 : `DCC_SEL_PIN0;
        first_pos_sel  = `DCC_SEL_PIN2;
        second_inv_sel = `DCC_SEL_PIN1;
        second_pos_sel = `DCC_SEL_PIN2;
        first_power    = 1'b1;
        second_power   = 1'b1;
        pin_analog     = 4'hF;
      end
      `DCC_MODE_FOURREF: begin
        first_inv_sel  = input_switch_select ? `DCC_SEL_PIN3 : `DCC_SEL_PIN0;
        second_inv_sel = input_switch_select ? `DCC_SEL_PIN2 : `DCC_SEL_PIN1;
        first_pos_sel  = `DCC_SEL_VREF;
        second_pos_sel = `DCC_SEL_VREF;
        first_power    = 1'b1;
        second_power   = 1'b1;
        pin_analog     = 4'hF;
      end
      `DCC_MODE_COMMON: begin
        first_inv_sel  = `DCC_SEL_PIN0;
        second_inv_sel = `DCC_SEL_PIN1;
        first_pos_sel  = `DCC_SEL_PIN2;
        second_pos_sel = `DCC_SEL_PIN2;
        first_power    = 1'b1;
        second_power   = 1'b1;
        pin_analog     = 4'h7;
      end
      `DCC_MODE_INDEP: begin
        first_inv_sel  = `DCC_SEL_PIN0;
        first_pos_sel  = `DCC_SEL_PIN3;
        second_inv_sel = `DCC_SEL_PIN1;
        second_pos_sel = `DCC_SEL_PIN2;
        first_power    = 1'b1;
        second_power   = 1'b1;
        pin_analog     = 4'hF;
      end
      `DCC_MODE_SINGLE: begin
        second_inv_sel = `DCC_SEL_PIN1;
        second_pos_sel = `DCC_SEL_PIN2;
        second_power   = 1'b1;
        pin_analog     = 4'h6;
      end
      `DCC_MODE_OUTPUTS: begin
        first_inv_sel  = `DCC_SEL_PIN0;
        second_inv_sel = `DCC_SEL_PIN1;
        first_pos_sel  = `DCC_SEL_PIN2;
        second_pos_sel = `DCC_SEL_PIN2;
        first_power    = 1'b1;
        second_power   = 1'b1;
        pin_analog     = 4'h7;
        result_drive   = 1'b1;
      end
      default: begin
        pin_analog = 4'h0;
      end
    endcase
  end

endmodule // dcc_mux_decode

// ### verif/dcc_assertions.sv
`timescale 1ns/10ps
`include "dcc_defines.vh"

module dcc_checker #(
  parameter ADDR_W = 12
) (
  // Bus
  input wire              hclk,
  input wire              hresetn,
  input wire              ce,
  input wire              hsel,
  input wire [ADDR_W-1:0] haddr,
  input wire [1:0]        htrans,
  input wire              hwrite,
  input wire [31:0]       hwdata,
  input wire              hready,
  input wire              hreadyout,
  input wire              hresp,
  input wire [31:0]       hrdata,
  // Analog side
  input wire              first_raw,
  input wire              second_raw,
  input wire [2:0]        first_inv_sel,
  input wire [2:0]        first_pos_sel,
  input wire [2:0]        second_inv_sel,
  input wire [2:0]        second_pos_sel,
  input wire              first_power,
  input wire              second_power,
  input wire [3:0]        pin_analog,
  // Pins and interrupt
  input wire [4:0]        port_data,
  input wire [4:0]        pin_out,
  input wire [4:0]        pin_oe,
  input wire              irq
);
  // ----------------------------------------------------------------
  // Register shadows
  // ----------------------------------------------------------------
  logic              ap_wr;
  logic              ap_rd;
  logic [ADDR_W-1:0] ap_a;
  logic [3:0]        ctl;
  logic              en;
  logic [1:0]        gate;
  wire               take = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr <= 1'b0;
      ap_rd <= 1'b0;
      ap_a  <= '0;
      ctl   <= 4'h0;
      en    <= 1'b0;
      gate  <= 2'h0;
    end else if (hreadyout) begin
      ap_wr <= take && hwrite;
      ap_rd <= take && !hwrite;
      ap_a  <= haddr;
      if (ap_wr && ap_a == 12'h07C) ctl <= hwdata[3:0];
      if (ap_wr && ap_a == 12'h088) en <= hwdata[0];
      if (ap_wr && ap_a == 12'h08C) gate <= hwdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_reply_okay: assert property (hreadyout == ce && hresp == `DCC_HRESP_OKAY)
    else $error("bus reply wrong");
  a_reset_off: assert property ($rose(hresetn) |-> !first_power && !second_power
    && pin_analog == 4'hF && pin_oe == 5'h00) else $error("reset state wrong");
  a_off_modes: assert property ((ctl[1:0] == {2{ctl[2]}} && $past(ctl) == ctl)
    |-> !first_power && !second_power) else $error("comparators powered in off mode");
  a_mode3_route: assert property ((ctl[2:0] == 3'h3 && $past(ctl) == ctl)
    |-> first_inv_sel == `DCC_SEL_PIN0 && second_inv_sel == `DCC_SEL_PIN1
    && first_pos_sel == `DCC_SEL_PIN2 && second_pos_sel == `DCC_SEL_PIN2)
    else $error("mode 3 routing wrong");
  a_mode1_switch: assert property ((ctl[2:0] == 3'h1 && $past(ctl) == ctl)
    |-> first_inv_sel == (ctl[3] ? `DCC_SEL_PIN3 : `DCC_SEL_PIN0))
    else $error("mode 1 switch wrong");
  a_mode2_switch: assert property ((ctl[2:0] == 3'h2 && $past(ctl) == ctl)
    |-> first_inv_sel == (ctl[3] ? `DCC_SEL_PIN3 : `DCC_SEL_PIN0)
    && second_inv_sel == (ctl[3] ? `DCC_SEL_PIN2 : `DCC_SEL_PIN1)
    && first_pos_sel == `DCC_SEL_VREF && second_pos_sel == `DCC_SEL_VREF)
    else $error("mode 2 routing wrong");
  a_raw_pins: assert property ((ctl[2:0] == 3'h6 && $past(ctl) == ctl)
    |-> pin_out[4:3] == {second_raw, first_raw}) else $error("raw outputs not on pins");
  a_digital_pins: assert property ((ctl[2:0] == 3'h3 && $past(ctl) == ctl)
    |-> pin_out[4:3] == port_data[4:3]) else $error("digital pins wrong");
  a_irq_gate: assert property (irq |-> en && gate == 2'h3)
    else $error("irq without enables");
  a_ro_zero: assert property ((ap_rd && ap_a == 12'h07C && hreadyout)
    |-> hrdata[5:4] == 2'h0) else $error("unused bits not zero");
endmodule // dcc_checker

bind dcc_top dcc_checker #(.ADDR_W(ADDR_W)) u_dcc_checker (.*);

// ### verif/dcc_analog_model.sv
`timescale 1ns/10ps

module dcc_analog_model (
  // Selects and power
  input  wire [2:0]  first_inv_sel,
  input  wire [2:0]  first_pos_sel,
  input  wire [2:0]  second_inv_sel,
  input  wire [2:0]  second_pos_sel,
  input  wire        first_power,
  input  wire        second_power,
  // Analog levels
  input  wire [31:0] pin_lvl,
  input  wire [7:0]  vref_lvl,
  // Results
  output wire        first_raw,
  output wire        second_raw
);
  wire [7:0] src [0:7];

  assign src[0] = 8'h00;
  assign src[1] = pin_lvl[7:0];
  assign src[2] = pin_lvl[15:8];
  assign src[3] = pin_lvl[23:16];
  assign src[4] = pin_lvl[31:24];
  assign src[5] = vref_lvl;
  assign src[6] = 8'h00;
  assign src[7] = 8'h00;
  // Powered down reads low
  assign first_raw  = first_power && (src[first_pos_sel] > src[first_inv_sel]);
  assign second_raw = second_power && (src[second_pos_sel] > src[second_inv_sel]);
endmodule // dcc_analog_model

// ### verif/tb.sv
`timescale 1ns/10ps

module tb;
  localparam [11:0] A_CTL = 12'h07C, A_DIR = 12'h214, A_STA = 12'h080;
  localparam [11:0] A_CLR = 12'h084, A_EN = 12'h088, A_GATE = 12'h08C;
  logic        hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, rd, pin_lvl = 32'hFF80F010;
  logic [7:0]  vref_lvl = 8'h40;
  logic [4:0]  port_data = 5'h15;
  logic [15:0] rt [4] = '{16'h0A0A, 16'h02C2, 16'h0989, 16'h01C1};
  wire         hready, hreadyout, hresp, first_raw, second_raw, first_power, second_power, irq;
  wire  [31:0] hrdata;
  wire  [2:0]  first_inv_sel, first_pos_sel, second_inv_sel, second_pos_sel;
  wire  [3:0]  pin_analog;
  wire  [4:0]  pin_out, pin_oe;
  int          failures = 0, n_tests = 0, cycles = 0;

  assign hready = hreadyout;
  dcc_top #(.ADDR_W(12)) u_dcc_top (.*);
  dcc_analog_model u_dcc_analog_model (.*);
  always #4 hclk = ~hclk;

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string m);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp, m);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd_chk(A_CTL, 32'h0, "control reset");
    rd_chk(A_DIR, 32'h1F, "direction reset");
    rd_chk(12'h3F0, 32'h0, "unmapped read");
    chk({first_power, second_power, pin_analog, pin_oe}, 32'h1E0, "pins at reset");
  endtask

  task automatic t_fields;
    pin_lvl = 32'h0;
    // Reference at ground so no mode raises a result bit
    vref_lvl <= 8'h00;
    for (int i = 0; i < 16; i++) begin
      xfer(1'b1, A_CTL, 32'hF0 | i);
      rd_chk(A_CTL, i, "control fields");
    end
  endtask

  task automatic t_results;
    pin_lvl <= 32'hFF80F010;
    vref_lvl <= 8'h40;
    xfer(1'b1, A_CTL, 32'h03);
    settle(4);
    rd_chk(A_CTL, 32'h43, "mode 3 results");
    pin_lvl <= 32'hFF800010;
    settle(4);
    rd_chk(A_CTL, 32'hC3, "both results");
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, A_CTL, rt[i][15:8]);
      settle(4);
      rd_chk(A_CTL, rt[i][7:0], "switch routing");
    end
  endtask

  task automatic t_irq;
    rd_chk(A_CTL, 32'hC1, "capture results");
    xfer(1'b1, A_CLR, 32'h1);
    rd_chk(A_STA, 32'h0, "flag cleared");
    xfer(1'b1, A_EN, 32'h1);
    xfer(1'b1, A_GATE, 32'h3);
    settle(1);
    chk(irq, 32'h0, "irq idle");
    pin_lvl <= 32'hFF80F0FF;
    settle(6);
    chk(irq, 32'h1, "irq raised");
    xfer(1'b1, A_CLR, 32'h1);
    rd_chk(A_STA, 32'h1, "mismatch holds flag");
    xfer(1'b0, A_CTL, 32'h0);
    xfer(1'b1, A_CLR, 32'h1);
    rd_chk(A_STA, 32'h0, "flag cleared after read");
    settle(1);
    chk(irq, 32'h0, "irq dropped");
    xfer(1'b1, A_GATE, 32'h1);
    pin_lvl <= 32'hFF80F010;
    settle(6);
    rd_chk(A_STA, 32'h1, "flag while masked");
    chk(irq, 32'h0, "irq masked");
  endtask

  task automatic t_pins;
    xfer(1'b1, A_CTL, 32'h06);
    xfer(1'b1, A_DIR, 32'h00);
    settle(2);
    chk(pin_oe, 32'h1F, "all pins drive");
    chk(pin_out[4:3], 32'h1, "raw on pins");
    chk(pin_out[2:0], 32'h5, "low pins digital");
    pin_lvl <= 32'hFF80F0FF;
    settle(1);
    chk(pin_out[4:3], 32'h0, "raw follows unsynced");
    xfer(1'b1, A_DIR, 32'h07);
    settle(1);
    chk(pin_oe, 32'h18, "direction gates pins");
    xfer(1'b1, A_CTL, 32'h03);
    settle(2);
    chk(pin_out[4:3], port_data[4:3], "digital pins");
  endtask

  // ----------------------------------------------------------------
  // Sequence and verdict
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("[FAIL] %0t run did not finish", $time);
      print_verdict();
    end
  end

  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_fields();
    t_results();
    t_irq();
    t_pins();
    print_verdict();
  end
endmodule // tb
